// >>> hdl/cop_param_diag.sv
// Parameter store, code-to-current scaling and diagnostic record of a
// four-channel current output module. Assumes codes and sense inputs are
// synchronous to CORE_CLK_I; the analog stage takes the microamp targets.

`timescale 1ns/1ps
`default_nettype none

module cop_param_diag (
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire cop_pkg::cop_prm_wr_t PRM_WR_I,
	input wire cop_pkg::cop_codes_t CODE_I,
	input wire logic [cop_pkg::NUM_CH-1:0] OPEN_LOOP_I,
	input wire logic MOD_FAIL_I,
	input wire logic INT_COMM_ERR_I,
	input wire logic AUX_MISSING_I,
	input wire cop_pkg::cop_rd_req_t RD_REQ_I,
	output cop_pkg::cop_rd_rsp_t RD_RSP_O,
	output cop_pkg::cop_ua_t CUR_UA_O,
	output logic [cop_pkg::NUM_CH-1:0] DRIVE_EN_O,
	output logic [cop_pkg::NUM_CH-1:0] CH_LED_O
);
	import cop_pkg::*;

	logic [7:0] wb_en_q;
	logic [NUM_CH-1:0][7:0] fn_q;
	logic [NUM_CH-1:0][7:0] ch_err_d, ch_err_q;
	logic [7:0] sum_diag_d, sum_diag_q, int_diag_d, int_diag_q;
	logic [6:0] pre_q;
	logic [31:0] us_q, ts_q;
	logic [7:0] rec [REC_LEN];

	function automatic logic fn_valid(input logic [7:0] fn);
		return fn == FN_F27_0_20 || fn == FN_F16_0_20 ||
			fn == FN_F27_4_20 || fn == FN_F16_4_20;
	endfunction

	// -----------------------------------------------------------------
	// Parameter store
	// -----------------------------------------------------------------
	// Enable byte and function numbers.
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wb_en_q <= WB_ENABLE_RESET;
		end else if (PRM_WR_I.we && PRM_WR_I.obj == KEY_WB_ENABLE) begin
			// Reserved upper bits are not kept so they always read zero.
			wb_en_q <= {4'h0, PRM_WR_I.data[3:0]};
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_fn
			always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					fn_q[g] <= FN_RESET;
				end else if (PRM_WR_I.we &&
					PRM_WR_I.obj == KEY_FN_CH0 + 16'(g)) begin
					fn_q[g] <= PRM_WR_I.data;
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Scaling
	// -----------------------------------------------------------------
	// The divisions are by constants, so synthesis folds them into
	// multiplier networks; this trades area for a single-cycle update.
	function automatic logic [14:0] scale(input logic signed [15:0] c,
		input logic [7:0] fn);
		logic signed [31:0] v, lo, hi, num, den, off, r;
		v = 32'(c);
		lo = 0;
		hi = 32511;
		num = 625;
		den = 864;
		off = 0;
		case (fn)
			FN_F16_0_20: begin
				hi = 20480;
				den = 512;
			end
			FN_F27_4_20: begin
				lo = -6912;
				num = 125;
				den = 216;
				off = 4000;
			end
			FN_F16_4_20: begin
				lo = -4096;
				hi = 20480;
				num = 125;
				den = 128;
				off = 4000;
			end
			default: begin
			end
		endcase
		if (v < lo) v = lo;
		if (v > hi) v = hi;
		r = v * num / den + off;
		if (r < 0) r = 0;
		return r[14:0];
	endfunction

	generate
		for (g = 0; g < NUM_CH; g++) begin : g_out
			always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					CUR_UA_O[g] <= 15'h0;
				end else if (fn_valid(fn_q[g])) begin
					CUR_UA_O[g] <= scale(CODE_I[g], fn_q[g]);
				end else begin
					CUR_UA_O[g] <= 15'h0;
				end
			end
			// Deactivated or misconfigured channel is not driven.
			always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					DRIVE_EN_O[g] <= 1'b0;
				end else begin
					DRIVE_EN_O[g] <= fn_valid(fn_q[g]);
				end
			end
			always_comb begin
				ch_err_d[g] = 8'h00;
				ch_err_d[g][CB_PARAM] = !fn_valid(fn_q[g]) &&
					fn_q[g] != FN_OFF;
				ch_err_d[g][CB_WIRE] = wb_en_q[g] &&
					fn_valid(fn_q[g]) && OPEN_LOOP_I[g];
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Diagnostic state
	// -----------------------------------------------------------------
	// Summary and internal bytes.
	always_comb begin
		sum_diag_d = 8'h00;
		sum_diag_d[SB_MOD_FAIL] = MOD_FAIL_I;
		sum_diag_d[SB_INTERNAL] = INT_COMM_ERR_I;
		sum_diag_d[SB_AUX] = AUX_MISSING_I;
		int_diag_d = 8'h00;
		int_diag_d[IB_COMM] = INT_COMM_ERR_I;
		for (int i = 0; i < NUM_CH; i++) begin
			sum_diag_d[SB_EXTERNAL] |= ch_err_d[i][CB_WIRE];
			sum_diag_d[SB_CHANNEL] |= |ch_err_d[i];
			sum_diag_d[SB_PARAM] |= ch_err_d[i][CB_PARAM];
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ch_err_q <= '0;
			sum_diag_q <= 8'h00;
			int_diag_q <= 8'h00;
		end else begin
			ch_err_q <= ch_err_d;
			sum_diag_q <= sum_diag_d;
			int_diag_q <= int_diag_d;
		end
	end

	// Channel indicators follow the recorded channel errors.
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CH_LED_O <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				CH_LED_O[i] <= |ch_err_d[i];
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pre_q <= 7'h0;
			us_q <= 32'h0;
		end else if (pre_q == 7'(US_CYCLES - 1)) begin
			pre_q <= 7'h0;
			us_q <= us_q + 32'h1;
		end else begin
			pre_q <= pre_q + 7'h1;
		end
	end

	wire diag_event = ch_err_d != ch_err_q || sum_diag_d != sum_diag_q ||
		int_diag_d != int_diag_q;

	// Timestamp of the latest change of the record.
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ts_q <= 32'h0;
		end else if (diag_event) begin
			ts_q <= us_q;
		end
	end

	// -----------------------------------------------------------------
	// Record and read port
	// -----------------------------------------------------------------
	// Record layout.
	always_comb begin
		for (int i = 0; i < REC_LEN; i++) begin
			rec[i] = 8'h00;
		end
		rec[B_SUMMARY] = sum_diag_q;
		rec[B_MODINFO] = MODINFO_VAL;
		rec[B_INTERNAL] = int_diag_q;
		rec[B_KIND] = CHANNEL_KIND_VAL;
		rec[B_NBITS] = DIAG_BITS_VAL;
		rec[B_NCH] = CHANNEL_COUNT_VAL;
		for (int i = 0; i < NUM_CH; i++) begin
			rec[B_CHSUM][i] = |ch_err_q[i];
			rec[B_CH0 + i] = ch_err_q[i];
			rec[B_TS + i] = ts_q[8*i +: 8];
		end
	end

	logic [7:0] rd_idx;
	logic rd_ok;

	always_comb begin
		rd_idx = RD_REQ_I.sel;
		rd_ok = 1'b0;
		case (RD_REQ_I.space)
			SP_RECORD_SET: begin
				rd_ok = (RD_REQ_I.key == SET_FULL && rd_idx < REC_LEN) ||
					(RD_REQ_I.key == SET_SHORT && rd_idx < SHORT_LEN);
			end
			SP_FIELDBUS_OBJ: begin
				rd_ok = (RD_REQ_I.key == OBJ_DIAG_FULL &&
					rd_idx < REC_LEN) || (RD_REQ_I.key == OBJ_DIAG_SHORT &&
					rd_idx < SHORT_LEN);
			end
			SP_SLAVE_SUB: begin
				rd_idx = RD_REQ_I.sel - SUB_FIRST;
				rd_ok = RD_REQ_I.key == SUB_DIAG_INDEX &&
					RD_REQ_I.sel >= SUB_FIRST && rd_idx < REC_LEN;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			RD_RSP_O <= '0;
		end else begin
			RD_RSP_O.valid <= RD_REQ_I.valid;
			RD_RSP_O.err <= RD_REQ_I.valid && !rd_ok;
			RD_RSP_O.data <= (RD_REQ_I.valid && rd_ok) ?
				rec[rd_idx[4:0]] : 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);

	sequence s_rd_kind;
		RD_REQ_I.valid && RD_REQ_I.space == SP_SLAVE_SUB &&
			RD_REQ_I.key == SUB_DIAG_INDEX && RD_REQ_I.sel == 8'h06;
	endsequence
	sequence s_rd_short_over;
		RD_REQ_I.valid && RD_REQ_I.space == SP_RECORD_SET &&
			RD_REQ_I.key == SET_SHORT && RD_REQ_I.sel > 8'h03;
	endsequence
	sequence s_fn0_write;
		PRM_WR_I.we && PRM_WR_I.obj == KEY_FN_CH0;
	endsequence
	sequence s_wb_write;
		PRM_WR_I.we && PRM_WR_I.obj == KEY_WB_ENABLE;
	endsequence

	a_wb_store: assert property (
		s_wb_write |=> wb_en_q == {4'h0, $past(PRM_WR_I.data[3:0])})
		else $error("wire-break enable not stored");
	a_fn_store: assert property (
		s_fn0_write |=> fn_q[0] == $past(PRM_WR_I.data) ##1
			DRIVE_EN_O[0] == fn_valid($past(PRM_WR_I.data, 2)))
		else $error("function number not applied");
	a_full_16k: assert property (
		fn_q[1] == FN_F16_0_20 && CODE_I[1] == 16'h4000 |=>
			CUR_UA_O[1] == 15'd20000)
		else $error("16384 did not give 20 mA");
	a_zero_16k: assert property (
		fn_q[0] == FN_F16_4_20 && CODE_I[0] == 16'h0000 |=>
			CUR_UA_O[0] == 15'd4000)
		else $error("code zero not 4 mA at 16384 scale");
	a_under_clamp: assert property (
		fn_q[3] == FN_F27_4_20 && $signed(CODE_I[3]) < -6912 |=>
			CUR_UA_O[3] == 15'h0)
		else $error("underrange not clamped");
	a_param_flag: assert property (
		!fn_valid(fn_q[2]) && fn_q[2] != FN_OFF |=>
			ch_err_q[2][CB_PARAM] && CH_LED_O[2])
		else $error("parameter error not flagged");
	a_wire_flag: assert property (
		wb_en_q[1] && fn_q[1] == FN_F27_4_20 && OPEN_LOOP_I[1] |=>
			ch_err_q[1][CB_WIRE] && sum_diag_q[SB_EXTERNAL])
		else $error("wire-break not flagged in 4-20 mA");
	a_rsp_pulse: assert property (
		RD_REQ_I.valid |=> RD_RSP_O.valid)
		else $error("read not answered");
	a_rsp_idle: assert property (
		!RD_REQ_I.valid |=> !RD_RSP_O.valid && RD_RSP_O.data == 8'h00)
		else $error("answer without request");

	a_wb_gated: assert property (
		!wb_en_q[0] |=> !ch_err_q[0][CB_WIRE])
		else $error("wire-break flagged on disabled channel");
	a_off_no_drive: assert property (
		fn_q[1] == FN_OFF |=> !DRIVE_EN_O[1] && CUR_UA_O[1] == 15'h0)
		else $error("deactivated channel driven");
	a_full_27k: assert property (
		fn_q[0] == FN_F27_0_20 && CODE_I[0] == 16'h6c00 |=>
			CUR_UA_O[0] == 15'd20000)
		else $error("27648 did not give 20 mA");
	a_zero_is_4ma: assert property (
		fn_q[0] == FN_F27_4_20 && CODE_I[0] == 16'h0000 |=>
			CUR_UA_O[0] == 15'd4000)
		else $error("code zero not 4 mA");
	a_over_saturate: assert property (
		fn_q[0] == FN_F16_0_20 && $signed(CODE_I[0]) > 20480 |=>
			CUR_UA_O[0] == 15'd25000)
		else $error("overrange not saturated");
	a_neg_clamp: assert property (
		fn_q[2] == FN_F27_0_20 && CODE_I[2][15] |=>
			CUR_UA_O[2] == 15'h0)
		else $error("negative code not clamped");
	a_short_set: assert property (
		s_rd_short_over |=> RD_RSP_O.valid && RD_RSP_O.err)
		else $error("short record set overread");
	a_kind_const: assert property (
		s_rd_kind |=> RD_RSP_O.data == CHANNEL_KIND_VAL && !RD_RSP_O.err)
		else $error("channel kind not 73h");
	a_ts_latch: assert property (
		diag_event |=> ts_q == $past(us_q))
		else $error("timestamp not latched");
	a_chan_summary: assert property (
		$rose(|ch_err_d[3]) |=> sum_diag_q[SB_CHANNEL] ##0 CH_LED_O[3])
		else $error("channel error not summarised");

endmodule

`default_nettype wire

// >>> include/cop_pkg.sv
// Constants and carrier types of the current output parameter/diagnostic
// block. Assumes one 100 MHz core clock and a backplane coupler that
// writes parameter objects and reads diagnostic bytes one at a time.
//
// Summary of operation
// - Wire-break enable byte: bit n enables channel n, bits 7..4 reserved.
// - Wire-break detection works in both 0-20 mA and 4-20 mA ranges.
// - Function number FFh switches the channel off; its output is not driven.
// - 31h is 0-20 mA at 27648 full scale, 41h at 16384.
// - 30h is 4-20 mA at 27648, 40h at 16384; code zero is 4 mA.
// - 27648 gives 20 mA; overrange to 32511 gives 23.52 or 22.81 mA.
// - 16384 gives 20 mA; overrange to 20480 gives 25 or 24 mA.
// - 0-20 clamps negatives to 0; 4-20 underrange -6912 or -4096 is 0 mA.
// - No interrupts; a channel error lights the channel indicator and is recorded.
// - Record reports parameter errors, and wire-break only where enabled.
// - Record set 01h reads the whole record, 00h its first four bytes.
// - Fieldbus index 2F01h reads the whole record, 2F00h four bytes.
// - Slave subindex 02h of index 5005h is the first diagnostic byte.
// - Summary byte bits 0,1,2,3,4,7: failure, internal, external, channel, aux, param.
// - Descriptor bytes read constant 73h, 08h and 04h.
// - Four channel error bytes follow, then four reserved zero bytes.
// - Channel error byte: bit 0 parameter error, bit 4 wire-break.
// - Channel error summary bit n flags an error in channel group n.
// - Free 32-bit microsecond counter from zero, latched at each diagnostic event.
// - After reset function numbers are 31h and wire-break detection is off.

package cop_pkg;
	localparam int NUM_CH = 4;
	localparam int REC_LEN = 20;
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
	// Parameter objects on the fieldbus index space.
	localparam logic [15:0] KEY_WB_ENABLE = 16'h3101;
	localparam logic [15:0] KEY_FN_CH0 = 16'h3102;
	localparam logic [7:0] WB_ENABLE_RESET = 8'h00;
	localparam logic [7:0] FN_RESET = 8'h31;
	localparam logic [7:0] FN_OFF = 8'hff;
	localparam logic [7:0] FN_F27_0_20 = 8'h31;
	localparam logic [7:0] FN_F16_0_20 = 8'h41;
	localparam logic [7:0] FN_F27_4_20 = 8'h30;
	localparam logic [7:0] FN_F16_4_20 = 8'h40;
	// Read address spaces.
	localparam logic [1:0] SP_RECORD_SET = 2'h0;
	localparam logic [1:0] SP_FIELDBUS_OBJ = 2'h1;
	localparam logic [1:0] SP_SLAVE_SUB = 2'h2;
	localparam logic [15:0] SET_SHORT = 16'h0000;
	localparam logic [15:0] SET_FULL = 16'h0001;
	localparam logic [15:0] OBJ_DIAG_SHORT = 16'h2f00;
	localparam logic [15:0] OBJ_DIAG_FULL = 16'h2f01;
	localparam logic [15:0] SUB_DIAG_INDEX = 16'h5005;
	localparam logic [7:0] SUB_FIRST = 8'h02;
	localparam int SHORT_LEN = 4;
	// Record byte positions and constant contents.
	localparam int B_SUMMARY = 0;
	localparam int B_MODINFO = 1;
	localparam int B_INTERNAL = 3;
	localparam int B_KIND = 4;
	localparam int B_NBITS = 5;
	localparam int B_NCH = 6;
	localparam int B_CHSUM = 7;
	localparam int B_CH0 = 8;
	localparam int B_TS = 16;
	localparam logic [7:0] MODINFO_VAL = 8'h15;
	localparam logic [7:0] CHANNEL_KIND_VAL = 8'h73;
	localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
	localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h04;
	// Bit positions.
	localparam int SB_MOD_FAIL = 0;
	localparam int SB_INTERNAL = 1;
	localparam int SB_EXTERNAL = 2;
	localparam int SB_CHANNEL = 3;
	localparam int SB_AUX = 4;
	localparam int SB_PARAM = 7;
	localparam int CB_PARAM = 0;
	localparam int CB_WIRE = 4;
	localparam int IB_COMM = 4;

	typedef logic [NUM_CH-1:0][15:0] cop_codes_t;
	typedef logic [NUM_CH-1:0][14:0] cop_ua_t;
	typedef struct packed {
		logic valid;
		logic [1:0] space;
		logic [15:0] key;
		logic [7:0] sel;
	} cop_rd_req_t;
	typedef struct packed {
		logic valid;
		logic err;
		logic [7:0] data;
	} cop_rd_rsp_t;
	typedef struct packed {
		logic we;
		logic [15:0] obj;
		logic [7:0] data;
	} cop_prm_wr_t;
endpackage

// >>> test/cop_coupler.sv
// Backplane coupler model: writes parameter bytes, reads diagnostic bytes.
// Assumes the block answers a read within three clock cycles.

`timescale 1ns/1ps
`default_nettype none

module cop_coupler (
	input wire logic clk_i,
	output var cop_pkg::cop_prm_wr_t prm_o,
	output var cop_pkg::cop_rd_req_t req_o,
	input wire cop_pkg::cop_rd_rsp_t rsp_i
);
	import cop_pkg::*;

	initial begin
		prm_o = '0;
		req_o = '0;
	end

	// Released lines carry inverted values so a stale one never passes.
	task automatic wr(input logic [15:0] key, input logic [7:0] dt);
		@(negedge clk_i);
		prm_o <= '{we: 1'b1, obj: key, data: dt};
		@(negedge clk_i);
		prm_o <= '{we: 1'b0, obj: ~key, data: ~dt};
	endtask

	task automatic rd(input logic [1:0] sp, input logic [15:0] key,
		input logic [7:0] sel, output logic [7:0] dt, output logic er,
		output bit ok);
		@(negedge clk_i);
		req_o <= '{valid: 1'b1, space: sp, key: key, sel: sel};
		@(negedge clk_i);
		req_o <= '{valid: 1'b0, space: ~sp, key: ~key, sel: ~sel};
		ok = 0;
		for (int n = 0; n < 3 && !ok; n++) begin
			if (rsp_i.valid === 1'b1) begin
				ok = 1;
				dt = rsp_i.data;
				er = rsp_i.err;
			end else begin
				@(negedge clk_i);
			end
		end
	endtask
endmodule

`default_nettype wire

// >>> test/test_current_output_param_diag.sv
// Self-checking bench for the current output parameter/diagnostic block.
// Assumes the coupler model drives the parameter and read ports.

`timescale 1ns/1ps
`default_nettype none

module test_current_output_param_diag;
	import cop_pkg::*;
	logic CORE_CLK_I = 0;
	logic RST_B_I = 0;
	cop_prm_wr_t prm;
	cop_rd_req_t req;
	cop_rd_rsp_t rsp;
	cop_codes_t code = '0;
	cop_ua_t cur;
	logic [3:0] open = '0;
	logic [3:0] drv;
	logic [3:0] led;
	logic fail = 0, comm = 0, aux = 0;
	int err_count = 0, check_count = 0, cyc = 0, tev = 0;
	int fn[4] = '{default: 'h31};
	int fl[6] = '{'h31, 'h41, 'h30, 'h40, 'hff, 'h55};
	int wf[4] = '{'h31, 'h30, 'h41, 'h55};
	int ev[12] = '{0, 16384, -32768, -7000, 27648, 32511, -1, 100, 32767,
		-6912, -4096, 20480};
	logic [7:0] wb = 0;
	logic [7:0] d;
	logic e;
	bit ok;

	cop_param_diag dut (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
		.PRM_WR_I(prm), .CODE_I(code), .OPEN_LOOP_I(open), .MOD_FAIL_I(fail),
		.INT_COMM_ERR_I(comm), .AUX_MISSING_I(aux), .RD_REQ_I(req),
		.RD_RSP_O(rsp), .CUR_UA_O(cur), .DRIVE_EN_O(drv), .CH_LED_O(led));
	cop_coupler bus (.clk_i(CORE_CLK_I), .prm_o(prm), .req_o(req),
		.rsp_i(rsp));

	initial forever #5 CORE_CLK_I = ~CORE_CLK_I;
	always @(posedge CORE_CLK_I) cyc <= cyc + 1;

	function automatic int lim(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	function automatic bit fok(int f);
		return f == 'h30 || f == 'h31 || f == 'h40 || f == 'h41;
	endfunction
	function automatic int ua(int f, int v);
		case (f)
		'h31: return lim(v, 0, 32511) * 625 / 864;
		'h41: return lim(v, 0, 20480) * 625 / 512;
		'h30: return lim(v, -6912, 32511) * 125 / 216 + 4000;
		'h40: return lim(v, -4096, 20480) * 125 / 128 + 4000;
		default: return 0;
		endcase
	endfunction
	function automatic logic [7:0] cerr(int i);
		return {3'h0, wb[i] & fok(fn[i]) & open[i], 3'h0,
			!fok(fn[i]) && fn[i] != 'hff};
	endfunction
	function automatic logic [7:0] rec(int k);
		logic [7:0] c;
		logic [7:0] s;
		logic [3:0] cs;
		s = {3'h0, aux, 2'h0, comm, fail};
		for (int i = 0; i < 4; i++) begin
			c = cerr(i);
			cs[i] = |c;
			s = s | {c[0], 3'h0, |c, c[4], 2'h0};
		end
		case (k)
		0: return s;
		1: return 8'h15;
		3: return {3'h0, comm, 4'h0};
		4: return 8'h73;
		5: return 8'h08;
		6: return 8'h04;
		7: return {4'h0, cs};
		8, 9, 10, 11: return cerr(k - 8);
		default: return 8'h00;
		endcase
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x,
		input int t, input string m);
		check_count++;
		if (!(g === x || (t > 0 && (g === x + 1 || g === x - 1)))) begin
			err_count++;
			$display("mismatch at %0t: %s got %0h want %0h", $time, m, g, x);
		end
	endtask
	task automatic rk(int sp, int k);
		logic [15:0] key;
		key = sp == 0 ? 16'h0001 : (sp == 1 ? 16'h2f01 : 16'h5005);
		bus.rd(sp[1:0], key, sp == 2 ? k[7:0] + 8'h02 : k[7:0], d, e, ok);
		chk({31'h0, ok & !e}, 1, 0, "read answered");
	endtask
	// A negative ts skips the timestamp, whose latch moment is loose.
	task automatic chk_rec(int sp, int ts, int t);
		logic [31:0] g;
		for (int k = 0; k < 20; k++) begin
			rk(sp, k);
			if (k < 16)
				chk(d, rec(k), 0, "record byte");
			else
				g[8*(k-16) +: 8] = d;
		end
		if (ts >= 0)
			chk(g, ts, t, "timestamp");
	endtask
	task automatic chk_out();
		repeat (3) @(negedge CORE_CLK_I);
		for (int i = 0; i < 4; i++) begin
			chk(cur[i], ua(fn[i], $signed(code[i])), 1, "current");
			chk(drv[i], fok(fn[i]), 0, "drive");
			chk(led[i], |cerr(i), 0, "indicator");
		end
	endtask
	task automatic setfn(int i, int f);
		fn[i] = f;
		bus.wr(16'h3102 + 16'(i), f[7:0]);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		conclude();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		void'($urandom(20554));
		repeat (3) @(negedge CORE_CLK_I);
		RST_B_I = 1;
		chk_out();
		chk_rec(0, 0, 0);
		for (int k = 0; k < 5; k++) begin
			bus.rd(2'h0, 16'h0000, k[7:0], d, e, ok);
			chk({e, d}, k < 4 ? {1'b0, rec(k)} : 9'h100, 0, "short");
			bus.rd(2'h1, 16'h2f00, k[7:0], d, e, ok);
			chk({e, d}, k < 4 ? {1'b0, rec(k)} : 9'h100, 0, "short");
		end
		bus.rd(2'h2, 16'h5005, 8'h01, d, e, ok);
		chk({e, d}, 9'h100, 0, "below first subindex");
		$display("test access done");
		foreach (fl[j]) begin
			for (int i = 0; i < 4; i++)
				setfn(i, fl[j]);
			for (int n = 0; n < 6; n++) begin
				@(negedge CORE_CLK_I);
				for (int i = 0; i < 4; i++)
					code[i] = 16'(n < 3 ? ev[(4 * n + i) % 12] : $urandom);
				chk_out();
			end
			chk_rec(j % 3, -1, 0);
		end
		$display("test scaling done");
		for (int i = 0; i < 4; i++)
			setfn(i, wf[i]);
		wb = 8'hff;
		bus.wr(16'h3101, wb);
		repeat (250) @(negedge CORE_CLK_I);
		code = {4{16'd100}};
		open = 4'hf;
		tev = cyc;
		chk_out();
		chk_rec(2, (tev - 3) / 100, 1);
		wb = 8'hf5;
		bus.wr(16'h3101, wb);
		chk_out();
		chk_rec(1, -1, 0);
		$display("test wire-break done");
		for (int j = 0; j < 3; j++) begin
			@(negedge CORE_CLK_I);
			{aux, comm, fail} = 3'(1 << j);
			chk_out();
			chk_rec(j, -1, 0);
		end
		{aux, comm, fail} = 3'h0;
		open = 4'h0;
		RST_B_I = 0;
		fn = '{default: 'h31};
		wb = 0;
		@(negedge CORE_CLK_I);
		RST_B_I = 1;
		chk_out();
		chk_rec(0, -1, 0);
		$display("test flags and reset done");
		conclude();
	end
endmodule

`default_nettype wire
